// file: design/whrg_pkg.sv
/*
 * Types for the warning history and run gate block.
 * Assumes whrg_regs.svh supplies the numeric constants.
 */
package whrg_pkg;
    // Settled copy of the operator and controller inputs
    typedef struct packed {
        logic panel_run;
        logic forward_run_input;
        logic reverse_run_input;
    } whrg_run_in_t;

    // Active warning conditions
    typedef struct packed {
        logic overheat;
        logic overload;
        logic assign_err;
    } whrg_warn_src_t;

    typedef enum logic [2:0] {
        WHRG_ST_STOP  = 3'b001,
        WHRG_ST_RUN   = 3'b010,
        WHRG_ST_ALARM = 3'b100
    } whrg_state_t;
endpackage

// file: design/whrg_regs.svh
/*
 * Constants for the warning history and run gate block: register offsets,
 * field positions, reset values and codes.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef WHRG_REGS_SVH
`define WHRG_REGS_SVH

// Register offsets (byte addresses, 32-bit words)
`define WHRG_OFF_CTRL      8'h00
`define WHRG_OFF_STATUS    8'h04
`define WHRG_OFF_INT_STAT  8'h08
`define WHRG_OFF_INT_MASK  8'h0C
`define WHRG_OFF_HCOUNT    8'h10
`define WHRG_OFF_HIST0     8'h20
`define WHRG_HIST_DEPTH    4'h9

// Control register fields
`define WHRG_CTRL_EXT_LO   0
`define WHRG_CTRL_VIEW_LO  2
`define WHRG_CTRL_HCLR     4
`define WHRG_CTRL_RESET    32'h0000_0000

// External-run setting values
`define WHRG_EXT_PANEL     2'h0
`define WHRG_EXT_ENABLED   2'h1
`define WHRG_EXT_ALT       2'h2

// Initial view selection: speed code
`define WHRG_VIEW_SPEED    2'h0

// Warning type codes; 0 means an empty history slot
`define WHRG_WARN_NONE     4'h0
`define WHRG_WARN_HEAT     4'h1
`define WHRG_WARN_LOAD     4'h2
`define WHRG_WARN_ASSIGN   4'h3

// Interrupt bits
`define WHRG_INT_WARN      0
`define WHRG_INT_ALARM     1
`define WHRG_INT_W         2

`endif

// file: design/whrg_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of pin levels.
 * Assumes the inputs are asynchronous to ref_clk_in.
 */
`timescale 1ns/1ps
module whrg_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk_in,
    input  wire logic         reset_in,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// file: design/whrg_top.sv
/*
 * Warning history and run gate: keeps a volatile history of up to nine
 * warning events and decides whether the motor may run.
 * Assumes a 125 MHz ref_clk_in, synchronous reset_in standing in for
 * power-up, pins asynchronous, register port on the same clock.
 */
`timescale 1ns/1ps
`include "whrg_regs.svh"
module whrg_top
    import whrg_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // Panel and controller pins
    input  wire logic        panel_run_in,
    input  wire logic        forward_run_input_in,
    input  wire logic        reverse_run_input_in,
    // Protection inputs, same clock domain
    input  wire logic        overheat_in,
    input  wire logic        overload_in,
    input  wire logic        assign_err_in,
    input  wire logic        alarm_in,
    input  wire logic        alarm_reset_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Results
    output logic             motor_run_out,
    output logic             motor_rev_out,
    output logic             warning_output_out,
    output logic             show_speed_out,
    output logic             irq_out
);
    whrg_run_in_t   run_s;
    whrg_warn_src_t warn_s;
    whrg_state_t    state_q;
    whrg_state_t    state_d;
    logic [1:0]     ext_q;
    logic [1:0]     view_q;
    logic [3:0]     hist_q [0:8];
    logic [3:0]     hcount_q;
    logic [3:0]     last_q;
    logic [3:0]     new_code;
    logic           run_ok;
    logic           want_rev;
    logic           hclr;
    logic [2:0]     ist_q;
    logic [2:0]     imask_q;
    logic [2:0]     iev;
    logic           warn_prev_q;
    logic           alarm_prev_q;

    // Pins pass two flops before anything reads them
    whrg_sync #(.W(3)) u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .async_in   ({panel_run_in, forward_run_input_in, reverse_run_input_in}),
        .sync_out   (run_s)
    );

    assign warn_s = '{overheat: overheat_in, overload: overload_in,
                      assign_err: assign_err_in};

    // Highest-priority active warning code
    function automatic logic [3:0] warn_code(input whrg_warn_src_t w);
        if (w.overheat)
            warn_code = `WHRG_WARN_HEAT;
        else if (w.overload)
            warn_code = `WHRG_WARN_LOAD;
        else if (w.assign_err)
            warn_code = `WHRG_WARN_ASSIGN;
        else
            warn_code = `WHRG_WARN_NONE;
    endfunction

    // Write strobe aimed at one register; every decode compares the full byte address,
    // so an aliased offset cannot reach a control register by accident
    function automatic logic wr_at(input logic       wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] off);
        wr_at = wr && (addr == off);
    endfunction

    assign new_code = warn_code(warn_s);
    // Clear bit is a strobe, never stored, so it reads back as zero
    assign hclr     = wr_at(reg_wr_in, reg_addr_in, `WHRG_OFF_CTRL)
                      && reg_wdata_in[`WHRG_CTRL_HCLR];

    // Run permission from the control source selection
    always_comb begin
        run_ok   = 1'b0;
        want_rev = 1'b0;
        if (ext_q == `WHRG_EXT_PANEL) begin
            run_ok = run_s.panel_run;
        end else begin
            // Exactly one direction requested is a valid command
            run_ok   = run_s.forward_run_input ^ run_s.reverse_run_input;
            want_rev = run_s.reverse_run_input;
        end
        // Assignment error stops the motor; overheat and overload do not
        if (warn_s.assign_err)
            run_ok = 1'b0;
    end

    // Run state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            WHRG_ST_STOP:  if (alarm_in) state_d = WHRG_ST_ALARM;
                           else if (run_ok) state_d = WHRG_ST_RUN;
            WHRG_ST_RUN:   if (alarm_in) state_d = WHRG_ST_ALARM;
                           else if (!run_ok) state_d = WHRG_ST_STOP;
            // Leave only on reset with the alarm cause gone
            WHRG_ST_ALARM: if (alarm_reset_in && !alarm_in) state_d = WHRG_ST_STOP;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            state_q <= WHRG_ST_STOP;
        else
            state_q <= state_d;
    end

    // Motor outputs follow the state; alarm always forces stop
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            motor_run_out <= 1'b0;
            motor_rev_out <= 1'b0;
        end else begin
            motor_run_out <= (state_d == WHRG_ST_RUN);
            motor_rev_out <= (state_d == WHRG_ST_RUN) && want_rev;
        end
    end

    // Control settings written by software
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ext_q  <= 2'(`WHRG_CTRL_RESET >> `WHRG_CTRL_EXT_LO);
            view_q <= 2'(`WHRG_CTRL_RESET >> `WHRG_CTRL_VIEW_LO);
        end else if (wr_at(reg_wr_in, reg_addr_in, `WHRG_OFF_CTRL)) begin
            ext_q  <= reg_wdata_in[`WHRG_CTRL_EXT_LO +: 2];
            view_q <= reg_wdata_in[`WHRG_CTRL_VIEW_LO +: 2];
        end
    end

    // Start-up view selection
    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            show_speed_out <= 1'b1;
        else
            show_speed_out <= (view_q == `WHRG_VIEW_SPEED);
    end

    // Warning output level
    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            warning_output_out <= 1'b0;
        else
            warning_output_out <= |warn_s;
    end

    // Warning history; volatile, so reset stands in for power loss
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || hclr) begin
            for (int i = 0; i < 9; i++)
                hist_q[i] <= `WHRG_WARN_NONE;
            hcount_q <= 4'h0;
            last_q   <= `WHRG_WARN_NONE;
        end else if (new_code != `WHRG_WARN_NONE && new_code != last_q) begin
            // A persisting warning is seen as one event; repeats skipped
            for (int i = 8; i > 0; i--)
                hist_q[i] <= hist_q[i-1];
            hist_q[0] <= new_code;
            last_q    <= new_code;
            if (hcount_q != `WHRG_HIST_DEPTH)
                hcount_q <= hcount_q + 4'h1;
        end
    end

    // Interrupt events: warning rise, alarm rise
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            warn_prev_q  <= 1'b0;
            alarm_prev_q <= 1'b0;
        end else begin
            warn_prev_q  <= |warn_s;
            alarm_prev_q <= alarm_in;
        end
    end
    assign iev = {1'b0, alarm_in && !alarm_prev_q, (|warn_s) && !warn_prev_q};

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ist_q   <= 3'h0;
            imask_q <= 3'h0;
        end else begin
            if (wr_at(reg_wr_in, reg_addr_in, `WHRG_OFF_INT_STAT))
                ist_q <= (ist_q & ~reg_wdata_in[2:0]) | iev;
            else
                ist_q <= ist_q | iev;
            if (wr_at(reg_wr_in, reg_addr_in, `WHRG_OFF_INT_MASK))
                imask_q <= reg_wdata_in[2:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(ist_q & imask_q);
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            reg_rdata_out <= 32'h0000_0000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `WHRG_OFF_CTRL:     reg_rdata_out <= {28'h0, view_q, ext_q};
                    `WHRG_OFF_STATUS:   reg_rdata_out <= {25'h0, state_q, motor_rev_out,
                                                         warning_output_out, last_q[1:0]};
                    `WHRG_OFF_INT_STAT: reg_rdata_out <= {29'h0, ist_q};
                    `WHRG_OFF_INT_MASK: reg_rdata_out <= {29'h0, imask_q};
                    `WHRG_OFF_HCOUNT:   reg_rdata_out <= {28'h0, hcount_q};
                    default: begin
                        // History slot one (newest) at HIST0
                        for (int i = 0; i < 9; i++)
                            if (reg_addr_in == `WHRG_OFF_HIST0 + 8'(4 * i))
                                reg_rdata_out <= {28'h0, hist_q[i]};
                    end
                endcase
            end
        end
    end

    // Checks
    sequence s_alarm_rise;
        alarm_in && !alarm_prev_q;
    endsequence

    // A new warning type that the history takes in
    sequence s_hist_store;
        !hclr && new_code != `WHRG_WARN_NONE && new_code != last_q;
    endsequence

    // Run gate
    a_alarm_stops: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        alarm_in |=> !motor_run_out) else $error("motor runs with alarm");
    a_alarm_holds: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_alarm_rise ##1 !alarm_reset_in |=> !motor_run_out)
        else $error("run before alarm reset");
    a_alarm_latch: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state_q == WHRG_ST_ALARM && !alarm_reset_in |=> state_q == WHRG_ST_ALARM)
        else $error("alarm left without reset");
    a_alarm_release: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state_q == WHRG_ST_ALARM && alarm_reset_in && !alarm_in |=> state_q == WHRG_ST_STOP)
        else $error("alarm not released");
    a_both_inputs: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ext_q != `WHRG_EXT_PANEL && run_s.forward_run_input && run_s.reverse_run_input
        |=> !motor_run_out) else $error("run with both inputs");
    a_no_inputs: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ext_q != `WHRG_EXT_PANEL && !run_s.forward_run_input && !run_s.reverse_run_input
        |=> !motor_run_out) else $error("run with no input");
    // One direction alone must start the motor when nothing else forbids it
    a_ext_runs: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ext_q != `WHRG_EXT_PANEL && (run_s.forward_run_input ^ run_s.reverse_run_input)
        && state_q != WHRG_ST_ALARM && !alarm_in && !warn_s.assign_err |=> motor_run_out)
        else $error("valid external command ignored");
    a_rev_in_run: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        motor_rev_out |-> motor_run_out) else $error("reverse without run");
    a_panel_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ext_q == `WHRG_EXT_PANEL && !run_s.panel_run |=> !motor_run_out)
        else $error("run in panel hold");
    a_panel_ignored: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ext_q != `WHRG_EXT_PANEL && !run_s.forward_run_input && run_s.panel_run
        && !run_s.reverse_run_input |=> !motor_run_out)
        else $error("panel acted under external");
    a_heat_runs: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        warn_s.overheat && state_q == WHRG_ST_RUN && run_ok && !alarm_in |=> motor_run_out)
        else $error("overheat stopped the motor");
    a_assign_stops: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        warn_s.assign_err |=> !motor_run_out) else $error("run with assignment error");

    // Outputs and display
    a_warn_out: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (|warn_s) |=> warning_output_out) else $error("warning output missed");
    a_warn_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !(|warn_s) |=> !warning_output_out) else $error("warning output stuck");
    a_view_speed: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        view_q == `WHRG_VIEW_SPEED |=> show_speed_out) else $error("speed view missed");
    a_view_other: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        view_q != `WHRG_VIEW_SPEED |=> !show_speed_out) else $error("speed shown wrongly");

    // History
    a_hist_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        hclr |=> hcount_q == 4'h0 && hist_q[0] == `WHRG_WARN_NONE)
        else $error("history not cleared");
    a_hist_cap: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        hcount_q <= `WHRG_HIST_DEPTH) else $error("history over nine");
    a_hist_push: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_hist_store |=> hist_q[0] == $past(new_code) && hist_q[1] == $past(hist_q[0]))
        else $error("history not shifted");
    a_hist_count: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_hist_store ##0 hcount_q != `WHRG_HIST_DEPTH
        |=> hcount_q == $past(hcount_q) + 4'h1)
        else $error("history count not advanced");
    a_hist_full: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_hist_store ##0 hcount_q == `WHRG_HIST_DEPTH |=> hcount_q == `WHRG_HIST_DEPTH)
        else $error("history count left nine");
    a_repeat_skip: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !hclr && new_code == last_q |=> $stable(hcount_q))
        else $error("repeat warning stored");

    // Interrupt and register port
    a_event_wins: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (|iev) |=> (ist_q & $past(iev)) == $past(iev)) else $error("status event lost");
    a_irq_high: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (|(ist_q & imask_q)) |=> irq_out) else $error("interrupt missed");
    a_irq_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !(|(ist_q & imask_q)) |=> !irq_out) else $error("interrupt without cause");
    a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000) else $error("read data not idle");
endmodule

// file: test/testbench.sv
/*
 * Self-checking bench for the warning history and run gate block.
 * Assumes the register constants header and the partner model.
 */
`timescale 1ns/1ps
`include "whrg_regs.svh"
module testbench;
    import whrg_pkg::*;
    typedef struct {logic [31:0] v; string n;} whrg_exp_t;
    logic        ref_clk_in = 1'b0;
    logic        reset_in   = 1'b1;
    logic        slow = 1'b0, panel_cmd = 1'b0, fwd_cmd = 1'b0, rev_cmd = 1'b0;
    wire         panel_run_in, forward_run_input_in, reverse_run_input_in;
    logic        overheat_in = 1'b0, overload_in = 1'b0, assign_err_in = 1'b0;
    logic        alarm_in = 1'b0, alarm_reset_in = 1'b0;
    logic [7:0]  reg_addr_in  = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_seen = 1'b0;
    logic [31:0] reg_rdata_out;
    logic        motor_run_out, motor_rev_out, warning_output_out, show_speed_out, irq_out;
    whrg_exp_t   exp_q[$];
    int          hist[$];
    int          last = 0, miscompares = 0, tests_run = 0, seed = 32'h2D8B62F0;

    // Clock at 125 MHz
    always #4 ref_clk_in = ~ref_clk_in;

    whrg_partner i_partner (.ref_clk_in, .slow_in(slow), .panel_cmd_in(panel_cmd),
        .fwd_cmd_in(fwd_cmd), .rev_cmd_in(rev_cmd), .panel_run_out(panel_run_in),
        .fwd_out(forward_run_input_in), .rev_out(reverse_run_input_in));
    whrg_top i_dut (.ref_clk_in, .reset_in, .panel_run_in, .forward_run_input_in,
        .reverse_run_input_in, .overheat_in, .overload_in, .assign_err_in, .alarm_in,
        .alarm_reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .motor_run_out, .motor_rev_out, .warning_output_out,
        .show_speed_out, .irq_out);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One bus cycle plus an idle cycle, so strobes never retrigger in one step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        reg_wr_in    <= w;
        reg_rd_in    <= ~w;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        exp_q.push_back('{e, n});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    // Pulse one warning source and keep the expected history
    task automatic warn(input int c);
        {overheat_in, overload_in, assign_err_in} <= 3'b100 >> (c - 1);
        settle(2);
        chk("warning_output_out", 32'h1, {31'h0, warning_output_out});
        {overheat_in, overload_in, assign_err_in} <= 3'b000;
        settle(3);
        if (c != last) begin
            hist.push_front(c);
        end
        last = c;
        if (hist.size() > 9) begin
            hist.pop_back();
        end
    endtask

    task automatic check_hist();
        rd(`WHRG_OFF_HCOUNT, hist.size(), "hcount");
        for (int i = 0; i < 9; i++) begin
            rd(`WHRG_OFF_HIST0 + 8'(4 * i), (i < hist.size()) ? hist[i] : 0, "slot");
        end
    endtask

    task automatic run_is(input logic e);
        settle(7);
        chk("motor_run_out", {31'h0, e}, {31'h0, motor_run_out});
    endtask

    // Read data watcher: compares the cycle after each taken read
    always @(posedge ref_clk_in) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("[ERR] read queue expected entry seen none");
            end else begin
                chk(exp_q[0].n, exp_q[0].v, reg_rdata_out);
                void'(exp_q.pop_front());
            end
        end
        rd_seen <= reg_rd_in;
    end

    // Watchdog against a hung sequence
    initial begin
        settle(20000);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        int f, r;
        settle(6);
        reset_in <= 1'b0;
        @(posedge ref_clk_in);
        chk("show_speed_out", 32'h1, {31'h0, show_speed_out});
        check_hist();
        bus(1'b1, 8'hFC, 32'hFFFFFFFF);
        rd(8'hFC, 32'h0, "unmapped");
        rd(`WHRG_OFF_CTRL, 32'h0, "ctrl");
        // Interrupt: raised while masked, then unmasked, then cleared
        warn(1);
        chk("irq_masked", 32'h0, {31'h0, irq_out});
        bus(1'b1, `WHRG_OFF_INT_MASK, 32'h1);
        settle(2);
        chk("irq_out", 32'h1, {31'h0, irq_out});
        bus(1'b1, `WHRG_OFF_INT_STAT, 32'h1);
        settle(2);
        chk("irq_cleared", 32'h0, {31'h0, irq_out});
        warn(1);
        for (int i = 0; i < 14; i++) begin
            warn(1 + ($unsigned($random(seed)) % 3));
        end
        check_hist();
        f = last;
        bus(1'b1, `WHRG_OFF_CTRL, 32'h10);
        hist.delete();
        last = 0;
        check_hist();
        warn(f);
        check_hist();
        // Power loss with the motor stopped and one entry stored: the volatile history must come back empty
        reset_in <= 1'b1;
        settle(2);
        reset_in <= 1'b0;
        hist.delete();
        last = 0;
        @(posedge ref_clk_in);
        check_hist();
        // Start-up view selection
        bus(1'b1, `WHRG_OFF_CTRL, 32'h4);
        settle(2);
        chk("show_speed_out", 32'h0, {31'h0, show_speed_out});
        bus(1'b1, `WHRG_OFF_CTRL, 32'h0);
        // Panel control: hold stops, run inputs ignored
        fwd_cmd <= 1'b1;
        run_is(1'b0);
        run_is(1'b0);
        fwd_cmd   <= 1'b0;
        panel_cmd <= 1'b1;
        run_is(1'b1);
        overheat_in <= 1'b1;
        run_is(1'b1);
        overheat_in <= 1'b0;
        alarm_in    <= 1'b1;
        run_is(1'b0);
        alarm_in <= 1'b0;
        run_is(1'b0);
        alarm_reset_in <= 1'b1;
        @(posedge ref_clk_in);
        alarm_reset_in <= 1'b0;
        run_is(1'b1);
        rd(`WHRG_OFF_STATUS, 32'h21, "status");
        rd(`WHRG_OFF_INT_STAT, 32'h3, "int_stat");
        // External settings, panel selector left at run
        for (int e = 1; e < 4; e++) begin
            bus(1'b1, `WHRG_OFF_CTRL, 32'(e));
            slow <= (e == 2);
            for (int k = 0; k < 4; k++) begin
                f = k >> 1;
                r = k & 1;
                {fwd_cmd, rev_cmd} <= k[1:0];
                run_is(1'(f ^ r));
                if ((f ^ r) != 0) begin
                    chk("motor_rev_out", 32'(r), {31'h0, motor_rev_out});
                end
            end
            {fwd_cmd, rev_cmd} <= 2'b00;
            settle(4);
        end
        settle(4);
        tally_and_finish();
    end
endmodule

// file: test/whrg_partner.sv
/*
 * Model of the operator panel selector and the external run controller.
 * Assumes the testbench commands levels just after rising clock edges.
 */
`timescale 1ns/1ps
module whrg_partner (
    // Clock and mode
    input  wire logic ref_clk_in,
    input  wire logic slow_in,
    // Commands from the testbench
    input  wire logic panel_cmd_in,
    input  wire logic fwd_cmd_in,
    input  wire logic rev_cmd_in,
    // Pins toward the block
    output logic      panel_run_out,
    output logic      fwd_out,
    output logic      rev_out
);
    logic [2:0] cmd_q;

    // One cycle of lag, like a sluggish relay contact
    always_ff @(posedge ref_clk_in) begin
        cmd_q <= {panel_cmd_in, fwd_cmd_in, rev_cmd_in};
    end

    // In slow mode the pins carry the lagged copy; otherwise the commands pass straight through
    assign {panel_run_out, fwd_out, rev_out} = slow_in ? cmd_q
                                             : {panel_cmd_in, fwd_cmd_in, rev_cmd_in};
endmodule
